// >>> ext_encoding_class.sv
`timescale 1ns/1ps
module ext_encoding_class (
  input wire logic [79:0] value,
  output logic is_zero,
  output logic is_denormal,
  output logic is_pseudo_denormal,
  output logic is_inf,
  output logic is_nan,
  output logic is_unsupported
);
  import x87_conv_pkg::*;

  logic [14:0] expo;
  logic int_bit;
  logic [62:0] frac;

  // field split: 15-bit exponent, explicit integer bit, 63-bit fraction
  // exponent integer fraction
  assign expo = value[78:64];
  assign int_bit = value[63];
  assign frac = value[62:0];

  // supported classes
  assign is_zero = (expo == 15'h0000) && !int_bit && (frac == 63'h0);
  assign is_denormal = (expo == 15'h0000) && !int_bit && (frac != 63'h0);
  assign is_pseudo_denormal = (expo == 15'h0000) && int_bit;
  assign is_inf = (expo == EXP_ALL1) && int_bit && (frac == 63'h0);
  assign is_nan = (expo == EXP_ALL1) && int_bit && (frac != 63'h0);

  // pseudo-nan, pseudo-infinity and unnormals
  // unsupported encodings
  assign is_unsupported = !int_bit && (expo != 15'h0000);

endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import x87_conv_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mem_rd;
  logic mem_wr;
  logic irq;
  logic [31:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  int err_total = 0;
  int checked = 0;
  always #20 mclk = ~mclk;
  x87_operand_conv uut (.MCLK(mclk), .SRST(srst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .IRQ(irq));
  x87_mem_model mem (.clk(mclk), .rd(mem_rd), .wr(mem_wr), .addr(mem_addr),
    .wdata(mem_wdata), .rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus helpers
  task automatic stop_test();
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [79:0] got, input logic [79:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    cmp(80'(pready), 80'h1, "pready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 8) begin
      @(posedge mclk);
      n++;
    end
    cmp(80'(irq), 80'(v), "irq");
  endtask
  // start one operation, wait for done, check and clear the flags
  task automatic run(input logic [31:0] ctrl, input logic [3:0] f);
    logic [31:0] q;
    int n;
    wr(ADDR_BASE, 32'h40);
    wr(ADDR_CTRL, ctrl | 32'h100);
    n = 0;
    do begin
      rd(ADDR_INT_STAT, q);
      n++;
    end while (q[0] !== 1'b1 && n < 40);
    cmp(80'(q[3:0]), 80'(f), "flags");
    wr(ADDR_INT_STAT, 32'hf);
  endtask
  task automatic load_chk(input logic [31:0] ctrl, input int nb, input logic [79:0] v,
                          input logic [79:0] exp, input logic [3:0] f);
    logic [31:0] r0;
    logic [31:0] r1;
    logic [31:0] r2;
    for (int i = 0; i < nb; i++) mem.mem[8'h40 + i] = v[8*i +: 8];
    run(ctrl, f);
    rd(ADDR_RES0, r0);
    rd(ADDR_RES1, r1);
    rd(ADDR_RES2, r2);
    cmp({r2[15:0], r1, r0}, exp, "load result");
  endtask
  task automatic store_chk(input logic [31:0] ctrl, input logic [79:0] src, input int nb,
                           input logic [79:0] exp, input logic [3:0] f);
    logic [79:0] got;
    for (int i = 0; i < 10; i++) mem.mem[8'h40 + i] = 8'hee;
    wr(ADDR_SRC0, src[31:0]);
    wr(ADDR_SRC1, src[63:32]);
    wr(ADDR_SRC2, {16'h0, src[79:64]});
    run(ctrl | 32'h38, f);
    got = '0;
    for (int i = 0; i < nb; i++) got[8*i +: 8] = mem.mem[8'h40 + i];
    cmp(got, exp, "stored bytes");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_regs();
    logic [31:0] q;
    rd(ADDR_CTRL, q);
    cmp(80'(q), 80'(CTRL_RST), "ctrl reset");
    rd(ADDR_INT_STAT, q);
    cmp(80'(q), 80'h0, "int_stat reset");
  endtask
  task automatic t_unmapped();
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h40, 32'h0, q, e);
    cmp(80'({e, q}), 80'h1_0000_0000, "unmapped read");
  endtask
  task automatic t_int_loads();
    load_chk(32'h30 | FMT_I16, 2, 80'h8000, 80'hc00e_8000_0000_0000_0000, 4'h1);
    load_chk(32'h30 | FMT_I32, 4, 80'h8000_0000, 80'hc01e_8000_0000_0000_0000, 4'h1);
    load_chk(32'h30 | FMT_I64, 8, 80'h8000_0000_0000_0000, 80'hc03e_8000_0000_0000_0000,
             4'h1);
    load_chk(32'h30 | FMT_BCD, 10, 80'h8000_0000_0000_0000_0012,
             80'hc002_c000_0000_0000_0000, 4'h1);
  endtask
  task automatic t_denormals();
    load_chk(32'h30 | FMT_SGL, 4, 80'h1, 80'h3f6a_8000_0000_0000_0000, 4'h5);
    load_chk(32'h30 | FMT_DBL, 8, 80'h1, 80'h3bcd_8000_0000_0000_0000, 4'h5);
    // unmasked denormal: flag raised, result left as it was
    load_chk(32'h20 | FMT_SGL, 4, 80'h1, 80'h3bcd_8000_0000_0000_0000, 4'h5);
  endtask
  task automatic t_unsupported();
    logic [79:0] bad [3];
    logic [31:0] q;
    bad = '{80'h7fff_0000_0000_0000_0001, 80'hffff_0000_0000_0000_0000,
            80'h3fff_0000_0000_0000_0001};
    for (int i = 0; i < 3; i++) begin
      load_chk(32'h30 | FMT_EXT, 10, bad[i], QNAN_IND, 4'h3);
      rd(ADDR_STATUS, q);
      cmp(80'({q[13], q[7:4]}), 80'h1a, "unsupported class, span");
    end
  endtask
  task automatic t_pseudo_denormal();
    load_chk(32'h30 | FMT_EXT, 10, 80'h0000_8000_0000_0000_0001,
             80'h0001_8000_0000_0000_0001, 4'h5);
  endtask
  task automatic t_stores();
    store_chk(32'(FMT_I32), 80'h3fff_8000_0000_0000_0000, 4, 80'h1, 4'h1);
    store_chk(32'(FMT_I16), 80'h7fff_8000_0000_0000_0000, 2, 80'h8000, 4'h3);
  endtask
  task automatic t_cmd_err();
    logic [31:0] q;
    logic [31:0] bad [2];
    bad = '{32'h137, 32'h138};
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, bad[i]);
      rd(ADDR_INT_STAT, q);
      cmp(80'(q[3:0]), 80'h8, "command error");
      wr(ADDR_INT_STAT, 32'hf);
    end
  endtask
  task automatic t_irq();
    logic [31:0] q;
    int n;
    wr(ADDR_INT_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h133);
    n = 0;
    do begin
      rd(ADDR_INT_STAT, q);
      n++;
    end while (q[0] !== 1'b1 && n < 40);
    wait_irq(1'b0);
    wr(ADDR_INT_MASK, 32'h1);
    wait_irq(1'b1);
    wr(ADDR_INT_STAT, 32'h1);
    wait_irq(1'b0);
  endtask
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    t_reset_regs();
    t_unmapped();
    t_int_loads();
    t_denormals();
    t_unsupported();
    t_pseudo_denormal();
    t_stores();
    t_cmd_err();
    t_irq();
    stop_test();
  end
endmodule

// >>> x87_conv_checker.sv
`timescale 1ns/1ps
module x87_conv_checker #(
  parameter int MEM_AW = 32
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [x87_conv_pkg::APB_AW-1:0] PADDR,
  input wire logic [x87_conv_pkg::APB_DW-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [MEM_AW-1:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic IRQ
);
  import x87_conv_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////////////////////
  // apb slave timing and decode
  a_ready_pulse:
    assert property (PREADY |=> !PREADY) else $error("pready longer than one cycle");
  a_ready_setup:
    assert property (PSEL && !PENABLE && CE |=> PREADY) else $error("no zero-wait answer");
  a_err_decode:
    assert property (PREADY |-> PSLVERR == (PADDR > ADDR_INT_MASK || PADDR[1:0] != 2'b00))
      else $error("pslverr does not match address");
  a_rdata_quiet:
    assert property (!PREADY || PWRITE |-> PRDATA == '0) else $error("prdata not zero");
  ////////////////////////////////////////////////////////////////////////////////
  // memory side byte sequencing
  a_rd_spacing:
    assert property (MEM_RD |=> !MEM_RD) else $error("reads closer than two cycles");
  a_rd_wr_excl:
    assert property (!(MEM_RD && MEM_WR)) else $error("read and write together");
  a_wr_step:
    assert property (MEM_WR && $past(MEM_WR) |-> MEM_ADDR == $past(MEM_ADDR) + 1)
      else $error("write address not ascending");
  a_rd_step:
    assert property (MEM_RD && $past(MEM_RD, 2) |-> MEM_ADDR == $past(MEM_ADDR, 2) + 1)
      else $error("read address not ascending");
  a_reset_quiet:
    assert property ($past(SRST) |-> !PREADY && !MEM_RD && !MEM_WR && !IRQ)
      else $error("outputs active after reset");
endmodule
bind x87_operand_conv x87_conv_checker #(.MEM_AW(MEM_AW)) chk (.MCLK(MCLK), .SRST(SRST),
  .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
  .IRQ(IRQ));

// >>> x87_conv_pkg.sv
package x87_conv_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // register byte offsets
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_BASE = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_SRC0 = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_SRC1 = 8'h0c;
  localparam logic [APB_AW-1:0] ADDR_SRC2 = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_RES0 = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_RES1 = 8'h18;
  localparam logic [APB_AW-1:0] ADDR_RES2 = 8'h1c;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h20;
  localparam logic [APB_AW-1:0] ADDR_INT_STAT = 8'h24;
  localparam logic [APB_AW-1:0] ADDR_INT_MASK = 8'h28;

  // control fields
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_STORE_BIT = 3;
  localparam int CTRL_DMASK_BIT = 4;
  localparam int CTRL_IMASK_BIT = 5;
  localparam int CTRL_START_BIT = 8;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SPAN_LSB = 4;
  localparam int STAT_CLS_LSB = 8;
  localparam int CLS_W = 6;

  // interrupt status / mask bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_INV = 1;
  localparam int IRQ_DEN = 2;
  localparam int IRQ_CMD = 3;

  // operand format codes
  localparam logic [2:0] FMT_SGL = 3'h0;
  localparam logic [2:0] FMT_DBL = 3'h1;
  localparam logic [2:0] FMT_EXT = 3'h2;
  localparam logic [2:0] FMT_I16 = 3'h3;
  localparam logic [2:0] FMT_I32 = 3'h4;
  localparam logic [2:0] FMT_I64 = 3'h5;
  localparam logic [2:0] FMT_BCD = 3'h6;

  // encoding constants
  localparam logic [14:0] EXT_BIAS = 15'h3fff;
  localparam logic [17:0] SGL_BIAS = 18'h0007f;
  localparam logic [17:0] DBL_BIAS = 18'h003ff;
  localparam logic [17:0] INT_TOP_EXP = 18'h0403e;
  localparam logic [14:0] EXP_ALL1 = 15'h7fff;
  localparam logic [14:0] EXP_ONE = 15'h0001;
  localparam logic [79:0] QNAN_IND = 80'hffff_c000_0000_0000_0000;
  localparam int BCD_DIGITS = 18;
  localparam int BCD_SIGN_BIT = 79;
  localparam logic [31:0] CTRL_RST = 32'h0000_0030;

  typedef enum logic [2:0] {S_IDLE, S_HOLD, S_CAPT, S_CONV, S_WRITE} seq_t;

  // byte span of each memory format
  function automatic logic [3:0] fmt_span(input logic [2:0] f);
    unique case (f)
      FMT_SGL: return 4'h4;
      FMT_DBL: return 4'h8;
      FMT_EXT: return 4'ha;
      FMT_I16: return 4'h2;
      FMT_I32: return 4'h4;
      FMT_I64: return 4'h8;
      FMT_BCD: return 4'ha;
      default: return 4'h0;
    endcase
  endfunction

endpackage

// >>> x87_mem_model.sv
`timescale 1ns/1ps
module x87_mem_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [256];
  ////////////////////////////////////////////////////////////////////////////////
  // byte valid one cycle after the strobe, toggling filler otherwise
  always @(posedge clk) begin
    if (rd) begin
      rdata <= mem[addr[7:0]];
    end else begin
      rdata <= ~rdata;
    end
    if (wr) begin
      mem[addr[7:0]] <= wdata;
    end
  end
  initial rdata = 8'h5a;
endmodule

// >>> x87_operand_conv.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - accept seven memory operand formats; stores take only extended and the three integer formats
// - loads convert to 80-bit extended format
// - masked single/double denormals get normalized
// - memory bytes little-endian, low first
// - address only by start, span from format
// - one reserved indefinite per format
// - integer 100..00 loads as most negative
// - masked invalid integer store writes indefinite
// - classify by exponent, integer bit, fraction
// - pseudo-nan, pseudo-inf, unnormal raise invalid; an extended store copies them without the flag
// - loads never output exponent zero with integer one; an extended store copies the source unchanged
// - pseudo-denormal: exponent one, denormal exception; an extended store copies it without the flag
module x87_operand_conv #(
  parameter int MEM_AW = 32
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [x87_conv_pkg::APB_AW-1:0] PADDR,
  input wire logic [x87_conv_pkg::APB_DW-1:0] PWDATA,
  output logic [x87_conv_pkg::APB_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [MEM_AW-1:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  output logic IRQ
);
  import x87_conv_pkg::*;

  if (MEM_AW < 8 || MEM_AW > 32) begin : g_bad_aw
    $error("MEM_AW must lie between 8 and 32");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    seq_t st;
    logic [2:0] fmt;
    logic store;
    logic dmask;
    logic imask;
    logic [MEM_AW-1:0] base;
    logic [79:0] src;
    logic [79:0] membuf;
    logic [79:0] res;
    logic [3:0] idx;
    logic [CLS_W-1:0] cls;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imsk;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [MEM_AW-1:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic irq;
  } state_t;

  localparam state_t RST_STATE = '{
    st: S_IDLE,
    fmt: CTRL_RST[CTRL_FMT_LSB +: 3],
    store: CTRL_RST[CTRL_STORE_BIT],
    dmask: CTRL_RST[CTRL_DMASK_BIT],
    imask: CTRL_RST[CTRL_IMASK_BIT],
    default: '0
  };

  state_t cur_ff;
  state_t nxt_cur;

  logic [APB_DW-1:0] rd_data;
  logic rd_hit;
  logic [79:0] cls_in;
  logic c_zero, c_den, c_pden, c_inf, c_nan, c_unsup;
  logic [79:0] cv_img;
  logic cv_inv;
  logic cv_den;
  logic [3:0] span;

  ////////////////////////////////////////////////////////////////////////////////
  // extended encoding classifier, fed by store source or loaded image
  assign cls_in = cur_ff.store ? cur_ff.src : cur_ff.membuf;

  ext_encoding_class u_class (
    .value(cls_in),
    .is_zero(c_zero),
    .is_denormal(c_den),
    .is_pseudo_denormal(c_pden),
    .is_inf(c_inf),
    .is_nan(c_nan),
    .is_unsupported(c_unsup)
  );

  assign span = fmt_span(cur_ff.fmt);

  // leading zero count of a 64-bit magnitude
  function automatic logic [6:0] lead_zeros(input logic [63:0] v);
    logic [6:0] n;
    logic found;
    n = 7'h40;
    found = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (!found && v[i]) begin
        n = 7'(63 - i);
        found = 1'b1;
      end
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // format conversion
  always_comb begin : conv_p
    logic [63:0] mag;
    logic [63:0] sint;
    logic [63:0] bin;
    logic [63:0] smag;
    logic [63:0] lim;
    logic [63:0] wmask;
    logic [14:0] sh;
    logic [17:0] bexp;
    logic [17:0] expn;
    logic [6:0] lz;
    logic [6:0] w;
    logic sgn;
    logic special;
    mag = '0;
    sint = '0;
    bin = '0;
    smag = '0;
    lim = '0;
    wmask = '0;
    sh = '0;
    bexp = '0;
    expn = '0;
    lz = '0;
    w = 7'h40;
    sgn = 1'b0;
    special = 1'b0;
    cv_img = cur_ff.res;
    cv_inv = 1'b0;
    cv_den = 1'b0;
    if (!cur_ff.store) begin
      unique case (cur_ff.fmt)
        FMT_SGL: begin
          sgn = cur_ff.membuf[31];
          special = &cur_ff.membuf[30:23];
          mag = {|cur_ff.membuf[30:23], cur_ff.membuf[22:0], 40'h0};
          bexp = (cur_ff.membuf[30:23] == 8'h00) ? 18'h1 : {10'h0, cur_ff.membuf[30:23]};
          bexp = bexp - SGL_BIAS + {3'h0, EXT_BIAS};
          cv_den = (cur_ff.membuf[30:23] == 8'h00) && (cur_ff.membuf[22:0] != 23'h0);
        end
        FMT_DBL: begin
          sgn = cur_ff.membuf[63];
          special = &cur_ff.membuf[62:52];
          mag = {|cur_ff.membuf[62:52], cur_ff.membuf[51:0], 11'h0};
          bexp = (cur_ff.membuf[62:52] == 11'h000) ? 18'h1 : {7'h0, cur_ff.membuf[62:52]};
          bexp = bexp - DBL_BIAS + {3'h0, EXT_BIAS};
          cv_den = (cur_ff.membuf[62:52] == 11'h000) && (cur_ff.membuf[51:0] != 52'h0);
        end
        FMT_I16, FMT_I32, FMT_I64: begin
          if (cur_ff.fmt == FMT_I16) begin
            sint = {{48{cur_ff.membuf[15]}}, cur_ff.membuf[15:0]};
          end else if (cur_ff.fmt == FMT_I32) begin
            sint = {{32{cur_ff.membuf[31]}}, cur_ff.membuf[31:0]};
          end else begin
            sint = cur_ff.membuf[63:0];
          end
          sgn = sint[63];
          mag = sgn ? (~sint + 64'h1) : sint;
          bexp = INT_TOP_EXP;
        end
        FMT_BCD: begin
          for (int d = BCD_DIGITS - 1; d >= 0; d--) begin
            bin = (bin << 3) + (bin << 1) + {60'h0, cur_ff.membuf[4*d +: 4]};
            if (cur_ff.membuf[4*d +: 4] > 4'h9) begin
              cv_inv = 1'b1;
            end
          end
          sgn = cur_ff.membuf[BCD_SIGN_BIT];
          mag = bin;
          bexp = INT_TOP_EXP;
        end
        default: begin
          mag = '0;
        end
      endcase
      lz = lead_zeros(mag);
      expn = bexp - {11'h0, lz};
      if (cur_ff.fmt == FMT_EXT) begin
        cv_img = cur_ff.membuf;
        cv_den = c_den || c_pden;
        cv_inv = c_unsup;
        if (c_pden) begin
          cv_img = {cur_ff.membuf[79], EXP_ONE, cur_ff.membuf[63:0]};
        end
      end else if (special) begin
        cv_img = {sgn, EXP_ALL1, 1'b1, mag[62:0]};
      end else if (mag == 64'h0) begin
        cv_img = {sgn, 79'h0};
      end else begin
        cv_img = {sgn, expn[14:0], mag << lz};
      end
      if (cv_inv && cur_ff.imask) begin
        cv_img = QNAN_IND;
      end
    end else if (cur_ff.fmt == FMT_EXT) begin
      cv_img = cur_ff.src;
    end else begin
      // integer store, truncating toward zero
      w = (cur_ff.fmt == FMT_I16) ? 7'h10 : (cur_ff.fmt == FMT_I32) ? 7'h20 : 7'h40;
      sgn = cur_ff.src[79];
      cv_den = c_den || c_pden;
      if (cur_ff.src[78:64] >= EXT_BIAS) begin
        sh = cur_ff.src[78:64] - EXT_BIAS;
        if (sh > 15'h003f) begin
          cv_inv = 1'b1;
        end else begin
          smag = cur_ff.src[63:0] >> (6'h3f - sh[5:0]);
        end
      end
      lim = (64'h1 << (w - 7'h1)) - (sgn ? 64'h0 : 64'h1);
      wmask = (w == 7'h40) ? {64{1'b1}} : ((64'h1 << w) - 64'h1);
      cv_inv = cv_inv || c_unsup || c_nan || c_inf || (smag > lim);
      smag = sgn ? (~smag + 64'h1) : smag;
      if (cv_inv) begin
        cv_img = {16'h0, 64'h1 << (w - 7'h1)};
      end else begin
        cv_img = {16'h0, smag & wmask};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    unique case (PADDR)
      ADDR_CTRL: begin
        rd_data[CTRL_FMT_LSB +: 3] = cur_ff.fmt;
        rd_data[CTRL_STORE_BIT] = cur_ff.store;
        rd_data[CTRL_DMASK_BIT] = cur_ff.dmask;
        rd_data[CTRL_IMASK_BIT] = cur_ff.imask;
      end
      ADDR_BASE: rd_data[MEM_AW-1:0] = cur_ff.base;
      ADDR_SRC0: rd_data = cur_ff.src[31:0];
      ADDR_SRC1: rd_data = cur_ff.src[63:32];
      ADDR_SRC2: rd_data[15:0] = cur_ff.src[79:64];
      ADDR_RES0: rd_data = cur_ff.res[31:0];
      ADDR_RES1: rd_data = cur_ff.res[63:32];
      ADDR_RES2: rd_data[15:0] = cur_ff.res[79:64];
      ADDR_STATUS: begin
        rd_data[STAT_BUSY_BIT] = (cur_ff.st != S_IDLE);
        rd_data[STAT_SPAN_LSB +: 4] = span;
        rd_data[STAT_CLS_LSB +: CLS_W] = cur_ff.cls;
      end
      ADDR_INT_STAT: rd_data[IRQ_W-1:0] = cur_ff.istat;
      ADDR_INT_MASK: rd_data[IRQ_W-1:0] = cur_ff.imsk;
      default: rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state: bus slave, sequencer, interrupts
  always_comb begin : next_p
    logic wr_en;
    logic idle;
    logic [IRQ_W-1:0] set_irq;
    logic [IRQ_W-1:0] clr_irq;
    logic exc;
    nxt_cur = cur_ff;
    nxt_cur.mem_rd = 1'b0;
    nxt_cur.mem_wr = 1'b0;
    nxt_cur.pready = 1'b0;
    nxt_cur.pslverr = 1'b0;
    nxt_cur.prdata = '0;
    set_irq = '0;
    clr_irq = '0;
    idle = (cur_ff.st == S_IDLE);
    wr_en = PSEL && PENABLE && cur_ff.pready && PWRITE;
    exc = (cv_inv && !cur_ff.imask) || (cv_den && !cur_ff.dmask);

    // setup phase answered in the following access cycle
    if (PSEL && !PENABLE) begin
      nxt_cur.pready = 1'b1;
      nxt_cur.pslverr = !rd_hit;
      // read data only for reads, writes answer with zero
      nxt_cur.prdata = PWRITE ? '0 : rd_data;
    end

    // register writes; configuration frozen while busy
    if (wr_en) begin
      unique case (PADDR)
        ADDR_CTRL: begin
          if (idle) begin
            nxt_cur.fmt = PWDATA[CTRL_FMT_LSB +: 3];
            nxt_cur.store = PWDATA[CTRL_STORE_BIT];
            nxt_cur.dmask = PWDATA[CTRL_DMASK_BIT];
            nxt_cur.imask = PWDATA[CTRL_IMASK_BIT];
          end
        end
        ADDR_BASE: if (idle) nxt_cur.base = PWDATA[MEM_AW-1:0];
        ADDR_SRC0: if (idle) nxt_cur.src[31:0] = PWDATA;
        ADDR_SRC1: if (idle) nxt_cur.src[63:32] = PWDATA;
        ADDR_SRC2: if (idle) nxt_cur.src[79:64] = PWDATA[15:0];
        ADDR_INT_STAT: clr_irq = PWDATA[IRQ_W-1:0];
        ADDR_INT_MASK: nxt_cur.imsk = PWDATA[IRQ_W-1:0];
        default: nxt_cur.imsk = cur_ff.imsk;
      endcase
    end

    unique case (cur_ff.st)
      S_IDLE: begin
        if (wr_en && PADDR == ADDR_CTRL && PWDATA[CTRL_START_BIT]) begin
          nxt_cur.idx = 4'h0;
          if (fmt_span(PWDATA[CTRL_FMT_LSB +: 3]) == 4'h0
              || (PWDATA[CTRL_STORE_BIT] && (PWDATA[CTRL_FMT_LSB +: 3] == FMT_SGL
              || PWDATA[CTRL_FMT_LSB +: 3] == FMT_DBL
              || PWDATA[CTRL_FMT_LSB +: 3] == FMT_BCD))) begin
            set_irq[IRQ_CMD] = 1'b1;
          end else if (PWDATA[CTRL_STORE_BIT]) begin
            nxt_cur.st = S_CONV;
          end else begin
            nxt_cur.st = S_HOLD;
            nxt_cur.mem_rd = 1'b1;
            nxt_cur.mem_addr = cur_ff.base;
            nxt_cur.membuf = '0;
          end
        end
      end
      S_HOLD: begin
        nxt_cur.st = S_CAPT;
      end
      S_CAPT: begin
        // byte idx lands at bits 8*idx
        nxt_cur.membuf[{cur_ff.idx, 3'h0} +: 8] = MEM_RDATA;
        if (cur_ff.idx == span - 4'h1) begin
          nxt_cur.st = S_CONV;
        end else begin
          nxt_cur.idx = cur_ff.idx + 4'h1;
          nxt_cur.mem_rd = 1'b1;
          nxt_cur.mem_addr = cur_ff.base + MEM_AW'(cur_ff.idx + 4'h1);
          nxt_cur.st = S_HOLD;
        end
      end
      S_CONV: begin
        nxt_cur.cls = {c_unsup, c_nan, c_inf, c_pden, c_den, c_zero};
        nxt_cur.idx = 4'h0;
        set_irq[IRQ_INV] = cv_inv;
        set_irq[IRQ_DEN] = cv_den;
        if (exc) begin
          // unmasked exception: destination untouched
          set_irq[IRQ_DONE] = 1'b1;
          nxt_cur.st = S_IDLE;
        end else begin
          nxt_cur.res = cv_img;
          if (cur_ff.store) begin
            nxt_cur.st = S_WRITE;
          end else begin
            set_irq[IRQ_DONE] = 1'b1;
            nxt_cur.st = S_IDLE;
          end
        end
      end
      S_WRITE: begin
        // store bytes low first, rising address
        nxt_cur.mem_wr = 1'b1;
        nxt_cur.mem_addr = cur_ff.base + MEM_AW'(cur_ff.idx);
        nxt_cur.mem_wdata = cur_ff.res[{cur_ff.idx, 3'h0} +: 8];
        nxt_cur.idx = cur_ff.idx + 4'h1;
        if (cur_ff.idx == span - 4'h1) begin
          set_irq[IRQ_DONE] = 1'b1;
          nxt_cur.st = S_IDLE;
        end
      end
    endcase

    // sticky status, set wins over clear
    nxt_cur.istat = (cur_ff.istat & ~clr_irq) | set_irq;
    nxt_cur.irq = |(nxt_cur.istat & nxt_cur.imsk);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cur_ff <= RST_STATE;
    end else if (CE) begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs straight from the state register
  assign PRDATA = cur_ff.prdata;
  assign PREADY = cur_ff.pready;
  assign PSLVERR = cur_ff.pslverr;
  assign MEM_ADDR = cur_ff.mem_addr;
  assign MEM_RD = cur_ff.mem_rd;
  assign MEM_WR = cur_ff.mem_wr;
  assign MEM_WDATA = cur_ff.mem_wdata;
  assign IRQ = cur_ff.irq;

endmodule
